// ==== shared/set_map.svh ====
// constants for the strobe event timestamp block
`ifndef SET_MAP_SVH
`define SET_MAP_SVH

// clock and time base
`define SET_CLK_PERIOD_NS 40
`define SET_MS_NS 1000000
`define SET_WEEK_MS 32'h240c8400

// pin positions
`define SET_PIN_A 0
`define SET_PIN_B 1
`define SET_PIN_C 2
`define SET_PIN_D 3
`define SET_NUM_PINS 4

// io_configuration_word fields
`define SET_CFG_EDGE_BIT 0
`define SET_CFG_PULSE_OUT_BIT 5

// hardware_status_word field
`define SET_HW_STROBE_EVENT_BIT 5

// startup and reset values
`define SET_BOOT_CYCLES 3'h4
`define SET_RST_WORD 32'h00000000

`endif

// ==== shared/set_pkg.sv ====
// types for the strobe event timestamp block
package set_pkg;
	typedef logic [31:0] set_word_t;
	typedef logic [3:0] set_pins_t;
	typedef logic [1:0] set_pin_idx_t;
	typedef enum logic [0:0] {
		SET_BOOT,
		SET_RUN
	} set_state_t;
endpackage

// ==== logic/set_pin_capture.sv ====
// one strobe pin: synchroniser and edge detector
module set_pin_capture (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// pin and configuration
	input wire logic i_pin,
	input wire logic i_edge_high,
	input wire logic i_enable,
	// results
	output logic o_level,
	output logic o_edge
);
	logic meta;
	logic sync;
	logic prev;

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			meta <= 1'h1;
			sync <= 1'h1;
			prev <= 1'h1;
		end else begin
			meta <= i_pin;
			sync <= meta;
			prev <= sync;
		end
	end

	// rising when edge bit set, falling otherwise
	assign o_edge = i_enable & (i_edge_high ? (sync & ~prev) : (~sync & prev));
	assign o_level = sync;
endmodule // set_pin_capture

// ==== logic/set_top.sv ====
// strobe input capture, timestamp and strobe output pulse
//
// Function
// - capture an event when an enabled strobe pin changes in the configured direction
// - edge bit zero means falling edge, one means rising edge
// - enable pull-up or pull-down on each capture-enabled strobe pin from the edge setting, except pin d while the pulse output is on
// - events are timestamped with one millisecond resolution
// - only the four pins capture, each only when configured as strobe input
// - select pin low at startup enables SPI, removing pins a and c from capture
// - internal pull-up holds select pin high at startup, leaving pins usable
// - each event requests a timestamp message and a navigation message
// - ascii messages by default, binary records when the port flag is set
// - record holds week, millisecond of week, pin and event index, 32 bits each
// - week counts GPS weeks, time of week counts milliseconds since Sunday
// - event sets the strobe bit of the hardware status word
// - when enabled, drive a one millisecond pulse at each inertial period start
// - strobe output active only while its enable bit is set
// - output pulse polarity follows the edge bit
// - timestamps use the GPS time base without leap seconds
`include "set_map.svh"

module set_top #(
	parameter int MS_CYCLES = `SET_MS_NS / `SET_CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_srst,
	// strobe pins a to d, d shared with pulse output
	input wire set_pkg::set_pins_t i_pin,
	output set_pkg::set_pins_t o_pull_up,
	output set_pkg::set_pins_t o_pull_down,
	output logic o_pin_d,
	output logic o_pin_d_oe,
	// configuration
	input wire set_pkg::set_word_t i_io_configuration_word,
	input wire set_pkg::set_pins_t i_capture_enable,
	input wire logic i_binary_strobe_output,
	// GPS time load
	input wire logic i_time_load,
	input wire set_pkg::set_word_t i_load_week,
	input wire set_pkg::set_word_t i_load_week_time_millis,
	// inertial period start
	input wire logic i_preintegrated_inertial_period,
	// message handshake
	input wire logic i_timestamp_ack,
	input wire logic i_nav_ack,
	input wire logic i_nav_record_sent,
	// status
	output logic o_spi_enabled,
	output logic o_time_valid,
	output set_pkg::set_word_t o_week,
	output set_pkg::set_word_t o_week_time_millis,
	output set_pkg::set_word_t o_hardware_status_word,
	// event record and requests
	output logic o_event,
	output set_pkg::set_word_t o_rec_week,
	output set_pkg::set_word_t o_rec_week_time_millis,
	output set_pkg::set_word_t o_rec_pin,
	output set_pkg::set_word_t o_rec_count,
	output logic o_timestamp_req,
	output logic o_nav_req,
	output logic o_req_binary
);
	import set_pkg::*;

	localparam int MS_CNT_W = $clog2(MS_CYCLES + 1);
	localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_CYCLES - 1);

	set_state_t state;
	logic [2:0] boot_cnt;
	logic edge_high;
	logic pulse_en;
	set_pins_t level;
	set_pins_t edges;
	set_pins_t pin_ok;
	logic any_edge;
	set_pin_idx_t first_pin;
	logic [MS_CNT_W-1:0] div_cnt;
	logic ms_tick;
	logic [MS_CNT_W-1:0] pulse_cnt;
	logic pulse_active;
	set_word_t next_week_time_millis;
	set_word_t next_week;
	set_word_t count;

	// lowest numbered pin wins when several fire together
	function automatic set_pin_idx_t lowest_pin(input set_pins_t p);
		set_pin_idx_t idx;
		idx = 2'h0;
		for (int k = `SET_NUM_PINS - 1; k >= 0; k--) begin
			if (p[k]) begin
				idx = set_pin_idx_t'(k);
			end
		end
		return idx;
	endfunction

	// pull towards the idle level of the chosen edge
	function automatic logic wants_pull_up(input logic high_edge);
		return ~high_edge;
	endfunction

	assign edge_high = i_io_configuration_word[`SET_CFG_EDGE_BIT];
	assign pulse_en = i_io_configuration_word[`SET_CFG_PULSE_OUT_BIT];

	// pin permission: spi takes a and c, pulse output takes d
	always_comb begin
		pin_ok = i_capture_enable;
		if (o_spi_enabled) begin
			pin_ok[`SET_PIN_A] = 1'h0;
			pin_ok[`SET_PIN_C] = 1'h0;
		end
		if (pulse_en) begin
			pin_ok[`SET_PIN_D] = 1'h0;
		end
		if (state != SET_RUN) begin
			pin_ok = 4'h0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `SET_NUM_PINS; g++) begin : g_pin
			set_pin_capture u_cap (
				.i_mclk(i_mclk),
				.i_srst(i_srst),
				.i_pin(i_pin[g]),
				.i_edge_high(edge_high),
				.i_enable(pin_ok[g]),
				.o_level(level[g]),
				.o_edge(edges[g])
			);
		end
	endgenerate

	assign any_edge = |edges;
	assign first_pin = lowest_pin(edges);

	// startup: let the select pin settle, then sample it once
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state <= SET_BOOT;
			boot_cnt <= 3'h0;
			o_spi_enabled <= 1'h0;
		end else begin
			unique case (state)
				SET_BOOT: begin
					if (boot_cnt == `SET_BOOT_CYCLES) begin
						o_spi_enabled <= ~level[`SET_PIN_B];
						state <= SET_RUN;
					end else begin
						boot_cnt <= boot_cnt + 3'h1;
					end
				end
				SET_RUN: begin
					state <= SET_RUN;
				end
			endcase
		end
	end

	// internal pulls
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_pull_up <= 4'h2;
			o_pull_down <= 4'h0;
		end else begin
			for (int k = 0; k < `SET_NUM_PINS; k++) begin
				o_pull_up[k] <= i_capture_enable[k] & wants_pull_up(edge_high);
				o_pull_down[k] <= i_capture_enable[k] & ~wants_pull_up(edge_high);
			end
			if (state == SET_BOOT) begin
				o_pull_up[`SET_PIN_B] <= 1'h1;
				o_pull_down[`SET_PIN_B] <= 1'h0;
			end
			if (pulse_en) begin
				o_pull_up[`SET_PIN_D] <= 1'h0;
				o_pull_down[`SET_PIN_D] <= 1'h0;
			end
		end
	end

	// one millisecond enable
	always_ff @(posedge i_mclk) begin
		if (i_srst || i_time_load) begin
			div_cnt <= '0;
			ms_tick <= 1'h0;
		end else if (div_cnt == MS_LAST) begin
			div_cnt <= '0;
			ms_tick <= 1'h1;
		end else begin
			div_cnt <= div_cnt + MS_CNT_W'(1);
			ms_tick <= 1'h0;
		end
	end

	// GPS week and millisecond of week, wraps at end of Saturday
	always_comb begin
		next_week = o_week;
		next_week_time_millis = o_week_time_millis + 32'h1;
		if (next_week_time_millis == `SET_WEEK_MS) begin
			next_week_time_millis = 32'h0;
			next_week = o_week + 32'h1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_week <= `SET_RST_WORD;
			o_week_time_millis <= `SET_RST_WORD;
			o_time_valid <= 1'h0;
		end else if (i_time_load) begin
			o_week <= i_load_week;
			o_week_time_millis <= i_load_week_time_millis;
			o_time_valid <= 1'h1;
		end else if (ms_tick) begin
			o_week <= next_week;
			o_week_time_millis <= next_week_time_millis;
		end
	end

	// event record
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			count <= `SET_RST_WORD;
			o_event <= 1'h0;
			o_rec_week <= `SET_RST_WORD;
			o_rec_week_time_millis <= `SET_RST_WORD;
			o_rec_pin <= `SET_RST_WORD;
			o_rec_count <= `SET_RST_WORD;
		end else begin
			o_event <= any_edge;
			if (any_edge) begin
				count <= count + 32'h1;
				o_rec_count <= count + 32'h1;
				o_rec_week <= o_week;
				o_rec_week_time_millis <= o_week_time_millis;
				o_rec_pin <= {30'h0, first_pin};
			end
		end
	end

	// message requests held until acknowledged, a new event wins over ack
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_timestamp_req <= 1'h0;
			o_nav_req <= 1'h0;
			o_req_binary <= 1'h0;
		end else begin
			if (any_edge) begin
				o_timestamp_req <= 1'h1;
				o_nav_req <= 1'h1;
				o_req_binary <= i_binary_strobe_output;
			end else begin
				if (i_timestamp_ack) begin
					o_timestamp_req <= 1'h0;
				end
				if (i_nav_ack) begin
					o_nav_req <= 1'h0;
				end
			end
		end
	end

	// strobe flag in the hardware status word, cleared once a nav record goes out
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_hardware_status_word <= `SET_RST_WORD;
		end else if (any_edge) begin
			o_hardware_status_word[`SET_HW_STROBE_EVENT_BIT] <= 1'h1;
		end else if (i_nav_record_sent) begin
			o_hardware_status_word[`SET_HW_STROBE_EVENT_BIT] <= 1'h0;
		end
	end

	// pulse length counter, restarts at each period start
	always_ff @(posedge i_mclk) begin
		if (i_srst || !pulse_en) begin
			pulse_cnt <= '0;
			pulse_active <= 1'h0;
		end else if (i_preintegrated_inertial_period) begin
			pulse_cnt <= '0;
			pulse_active <= 1'h1;
		end else if (pulse_active) begin
			if (pulse_cnt == MS_LAST) begin
				pulse_active <= 1'h0;
			end else begin
				pulse_cnt <= pulse_cnt + MS_CNT_W'(1);
			end
		end
	end

	// pin d drive
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_pin_d <= 1'h0;
			o_pin_d_oe <= 1'h0;
		end else begin
			o_pin_d_oe <= pulse_en;
			o_pin_d <= (pulse_en && (i_preintegrated_inertial_period || (pulse_active && pulse_cnt != MS_LAST)))
				? edge_high : ~edge_high;
		end
	end
endmodule // set_top

// ==== bench/set_chk.sv ====
// port assertions for the strobe event timestamp block
module set_chk #(
	parameter int MS_CYCLES = 20
) (
	// watched ports
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire set_pkg::set_word_t i_io_configuration_word,
	input wire logic i_time_load,
	input wire set_pkg::set_word_t i_load_week,
	input wire set_pkg::set_word_t i_load_week_time_millis,
	input wire logic i_preintegrated_inertial_period,
	input wire logic i_timestamp_ack,
	input wire set_pkg::set_pins_t o_pull_up,
	input wire set_pkg::set_pins_t o_pull_down,
	input wire logic o_pin_d,
	input wire logic o_pin_d_oe,
	input wire logic o_spi_enabled,
	input wire set_pkg::set_word_t o_week,
	input wire set_pkg::set_word_t o_week_time_millis,
	input wire set_pkg::set_word_t o_hardware_status_word,
	input wire logic o_event,
	input wire set_pkg::set_word_t o_rec_pin,
	input wire set_pkg::set_word_t o_rec_count,
	input wire logic o_timestamp_req,
	input wire logic o_nav_req
);
	timeunit 1ns;
	timeprecision 1ns;
	import set_pkg::*;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	int run;
	// active pulse cycles seen so far
	always_ff @(posedge i_mclk) begin
		if (i_srst || !o_pin_d_oe || o_pin_d != i_io_configuration_word[0]) run <= 0;
		else run <= run + 1;
	end
	property p_evt; o_event |=> !o_event; endproperty
	a_evt: assert property (p_evt) else $error("event pulse too long");
	property p_req; o_event |-> o_timestamp_req && o_nav_req; endproperty
	a_req: assert property (p_req) else $error("event without message requests");
	property p_stat; o_event |-> o_hardware_status_word[5] && o_rec_pin < 4; endproperty
	a_stat: assert property (p_stat) else $error("status bit or pin index wrong");
	property p_count; o_event |-> o_rec_count == $past(o_rec_count) + 1; endproperty
	a_count: assert property (p_count) else $error("event index not incremented");
	property p_oe; o_pin_d_oe |-> $past(i_io_configuration_word[5]); endproperty
	a_oe: assert property (p_oe) else $error("pulse output driven while disabled");
	property p_start;
		i_preintegrated_inertial_period && i_io_configuration_word[5] && $stable(i_io_configuration_word)
			|=> o_pin_d == $past(i_io_configuration_word[0]) && o_pin_d_oe;
	endproperty
	a_start: assert property (p_start) else $error("pulse not started");
	property p_idle;
		!i_io_configuration_word[5] && $stable(i_io_configuration_word) && !$past(i_srst)
			|=> o_pin_d == !$past(i_io_configuration_word[0]) && !o_pin_d_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("idle level wrong");
	property p_len; run <= MS_CYCLES; endproperty
	a_len: assert property (p_len) else $error("pulse too long");
	property p_ack; i_timestamp_ack |=> !o_timestamp_req || o_event; endproperty
	a_ack: assert property (p_ack) else $error("request not cleared");
	property p_load;
		i_time_load |=> o_week == $past(i_load_week) && o_week_time_millis == $past(i_load_week_time_millis);
	endproperty
	a_load: assert property (p_load) else $error("time load lost");
	property p_ms;
		$changed(o_week_time_millis) && !$past(i_time_load) && o_week_time_millis != 0
			|-> o_week_time_millis == $past(o_week_time_millis) + 1;
	endproperty
	a_ms: assert property (p_ms) else $error("time step not one ms");
	property p_pull; (o_pull_up & o_pull_down) == 4'h0; endproperty
	a_pull: assert property (p_pull) else $error("both pulls on");
	c_evt: cover property (o_event);
	c_pulse: cover property (o_pin_d_oe && o_pin_d == i_io_configuration_word[0]);
	c_spi: cover property ($rose(o_spi_enabled));
endmodule // set_chk

bind set_top set_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);

// ==== bench/set_src.sv ====
// trigger source model driving the four strobe pins
module set_src #(
	parameter int MS = 20
) (
	// clock
	input wire logic i_mclk,
	// strobe pins
	output logic [3:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_pin = 4'hf;
	task automatic drive(input int k, input logic v);
		@(posedge i_mclk);
		o_pin[k] <= v;
		repeat (MS + 6) @(posedge i_mclk);
	endtask
endmodule // set_src

// ==== bench/strobe_event_timestamp_test.sv ====
// self-checking bench for the strobe event timestamp block
module strobe_event_timestamp_test;
	timeunit 1ns;
	timeprecision 1ns;
	import set_pkg::*;
	localparam int MS = 20;
	logic i_mclk = 0, i_srst = 1, i_binary_strobe_output = 0, i_time_load = 0, ack = 0, ack2 = 0;
	logic i_preintegrated_inertial_period = 0, o_pin_d, o_pin_d_oe, o_spi_enabled, o_event;
	logic o_timestamp_req, o_nav_req, o_req_binary, o_time_valid;
	set_word_t i_io_configuration_word = '0, i_load_week = '0, i_load_week_time_millis = '0;
	set_word_t o_rec_week, o_rec_pin, o_rec_count, o_rec_week_time_millis, o_hardware_status_word;
	set_pins_t i_capture_enable = 4'hf, pin, o_pull_up, o_pull_down;
	int num_errors = 0, n_tests = 0, cnt = 0, seed = 121, tcnt = 0;
	int exp_q[$];
	always #20 i_mclk = ~i_mclk;
	set_src #(.MS(MS)) u_src (.i_mclk, .o_pin(pin));
	set_top #(.MS_CYCLES(MS)) uut (.i_mclk, .i_srst, .i_pin(pin), .o_pull_up, .o_pull_down, .o_pin_d,
		.o_pin_d_oe, .i_io_configuration_word, .i_capture_enable, .i_binary_strobe_output, .i_time_load,
		.i_load_week, .i_load_week_time_millis, .i_preintegrated_inertial_period, .i_timestamp_ack(ack),
		.i_nav_ack(ack), .i_nav_record_sent(ack), .o_spi_enabled, .o_time_valid, .o_week(),
		.o_week_time_millis(), .o_hardware_status_word, .o_event, .o_rec_week,
		.o_rec_week_time_millis, .o_rec_pin, .o_rec_count, .o_timestamp_req, .o_nav_req, .o_req_binary);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic hit(input int k, input logic v, input logic want);
		i_binary_strobe_output <= 1'($random(seed));
		if (want) exp_q.push_back(k);
		u_src.drive(k, v);
	endtask
	// event model and acknowledge
	always @(posedge i_mclk) begin
		// cycles since the divider restarted (load or last reset edge)
		tcnt = (i_srst || i_time_load) ? 0 : tcnt + 1;
		if (i_srst) cnt = 0;
		ack <= o_event;
		ack2 <= ack;
		if (ack2) begin
			check(o_timestamp_req, 0);
			check(o_nav_req, 0);
			check(o_hardware_status_word[5], 0);
		end
		if (o_event === 1'b1) begin
			cnt++;
			check(o_rec_week_time_millis, i_load_week_time_millis + 32'((tcnt - 3) / MS));
			check(o_hardware_status_word[5], 1);
			check(exp_q.size(), 1);
			if (exp_q.size() > 0) check(o_rec_pin, exp_q.pop_front());
			check(o_rec_count, cnt);
			check(o_rec_week, i_load_week);
			check(o_req_binary, i_binary_strobe_output);
			check(o_nav_req, 1);
		end
	end
	initial begin
		repeat (4) @(posedge i_mclk);
		check(o_pull_up, 4'h2);
		i_srst <= 0;
		repeat (8) @(posedge i_mclk);
		check(o_spi_enabled, 0);
		i_load_week <= $random(seed);
		i_load_week_time_millis <= $random(seed) & 32'hfffff;
		i_time_load <= 1;
		@(posedge i_mclk);
		i_time_load <= 0;
		for (int e = 0; e < 2; e++) begin
			i_io_configuration_word <= 32'(e);
			i_capture_enable <= 4'($random(seed)) | 4'h1;
			@(posedge i_mclk);
			for (int k = 0; k < 4; k++)
				for (int v = 0; v < 2; v++)
					hit(k, v, v == e && i_capture_enable[k]);
			check(o_pull_up, e ? 4'h0 : i_capture_enable);
			check(o_pull_down, e ? i_capture_enable : 4'h0);
		end
		for (int e = 0; e < 2; e++) begin
			i_io_configuration_word <= 32'h20 | 32'(e);
			repeat (3) @(posedge i_mclk);
			check(o_pin_d, !e);
			i_preintegrated_inertial_period <= 1;
			@(posedge i_mclk);
			i_preintegrated_inertial_period <= 0;
			@(posedge i_mclk);
			check(o_pin_d, e);
			check(o_pin_d_oe, 1);
			repeat (MS - 1) @(posedge i_mclk);
			check(o_pin_d, e);
			@(posedge i_mclk);
			check(o_pin_d, !e);
		end
		i_io_configuration_word <= '0;
		i_capture_enable <= 4'hf;
		i_load_week <= '0;
		i_load_week_time_millis <= '0;
		repeat (3) @(posedge i_mclk);
		check(o_pin_d_oe, 0);
		check(o_time_valid, 1);
		i_srst <= 1;
		u_src.drive(1, 0);
		i_srst <= 0;
		repeat (10) @(posedge i_mclk);
		check(o_spi_enabled, 1);
		check(o_time_valid, 0);
		hit(0, 0, 0);
		hit(2, 0, 0);
		hit(3, 0, 1);
		repeat (10) @(posedge i_mclk);
		check(exp_q.size(), 0);
		close_out();
	end
	initial begin
		#(40 * 3000);
		num_errors++;
		close_out();
	end
endmodule // strobe_event_timestamp_test
